// *** rtl/dac_fe_pkg.sv ***
package dac_fe_pkg;
	localparam int SAMPLE_W = 14;
	localparam int GAIN_W = 11;
	localparam int PHASE_W = 10;
	localparam int OFFSET_W = 13;
	localparam int SUM_W = 18;
	localparam int CLK_DIV = 2;
	localparam int FIFO_DEPTH = 4;
	localparam int TWO_APART = 2;
	localparam int ONE_APART = 1;
	localparam logic [12:0] I_OFFSET_RST = 13'h1600;
	localparam logic [12:0] Q_OFFSET_RST = 13'h1d7a;
	localparam logic [10:0] I_GAIN_RST = 11'h500;
	localparam logic [10:0] Q_GAIN_RST = 11'h218;
	localparam logic [9:0] PHASE_RST = 10'h200;
	localparam logic signed [17:0] SAT_MAX = 18'h0_1fff;
	localparam logic signed [17:0] SAT_MIN = 18'h3_e000;
	typedef enum logic {MODE_OUT_CLOCK, MODE_DDR} clock_mode_e;
endpackage

// *** rtl/dac_input_qmc.sv ***
// Overview of operation
// - Output-clock mode: converter clock divided by two forms the sample clock.
// - I sample marker resets divider phase and tags the I word.
// - Output-clock mode drives the word-rate data clock on the clock pin.
// - Sync pulse reinitialises processing; taken in I slot, Q slot, or both.
// - Output-clock mode passes through the sample FIFO; data latency follows its fill.
// - DDR mode: I latched on rising, Q on falling converter clock edge.
// - DDR mode passes through the sample FIFO; data latency follows its fill.
// - Full buffer drops arriving pairs; empty buffer deasserts conv_valid.
// - Two-apart alarm when pointers within two addresses.
// - One-apart alarm when pointers within one address.
// - Alarms are unclocked decodes; samplers must synchronise them.
// - Alarm pin driven only with alarm enable set, four-wire mode clear.
// - I and Q scaled by separate 11-bit unsigned gains, 0 to about 2.
// - 10-bit signed phase term spans -1/8 to about +1/8.
// - Signed 13-bit offsets added to I and Q before conversion.
// - Gain applied before offset addition.
// - Both offsets go live only on the I offset low byte write.
// - Gains and phase go live only on the I gain low byte write.
`timescale 1ns/1ps

module sample_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign in_ready = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign count = cnt_q;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (flush)
		begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end
		else
		begin
			if (push)
			begin
				mem_d[wr_q] = in_data;
				wr_d = bump(wr_q);
			end
			if (pop)
				rd_d = bump(rd_q);
			cnt_d = cnt_q + CW'(push) - CW'(pop);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			for (int k = 0; k < DEPTH; k++)
				mem_q[k] <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			mem_q <= mem_d;
		end
	end
endmodule

module dac_input_qmc #(
	parameter int DEPTH = dac_fe_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire dac_fe_pkg::clock_mode_e clock_mode,
	input wire logic converter_clock_diff,
	input wire logic i_sample_marker,
	input wire logic sync_pulse,
	input wire logic [13:0] word_in,
	output logic data_clk_pin_o,
	output logic data_clk_pin_oe,
	input wire logic [10:0] i_gain_value,
	input wire logic [10:0] q_gain_value,
	input wire logic [9:0] phase_value,
	input wire logic [12:0] i_offset_value,
	input wire logic [12:0] q_offset_value,
	input wire logic i_gain_low_byte_wr,
	input wire logic i_offset_low_byte_wr,
	input wire logic alarm_output_enable,
	input wire logic four_wire_serial_mode,
	output logic fifo_two_apart_flag,
	output logic fifo_one_apart_flag,
	output logic alarm_pin_o,
	output logic alarm_pin_oe,
	output logic sample_ready,
	output logic conv_valid,
	input wire logic conv_ready,
	output logic [13:0] conv_i,
	output logic [13:0] conv_q
);
	localparam int CW = $clog2(DEPTH+1);
	localparam int SW = dac_fe_pkg::SAMPLE_W;
	// Pin synchronisers: first stage read only by second stage
	logic [SW+2:0] meta_q, pin_q;
	logic clk_s, marker_s, sync_s;
	logic [SW-1:0] data_s;
	logic clk_prev_q, rise, fall;
	logic [$clog2(dac_fe_pkg::CLK_DIV)-1:0] slot_q, slot_d;
	logic [SW-1:0] i_hold_q, i_hold_d, i_q, i_d, q_q, q_d;
	logic pair_valid_q, pair_valid_d;
	logic [10:0] gi_q, gi_d, gq_q, gq_d;
	logic [9:0] ph_q, ph_d;
	logic [12:0] oi_q, oi_d, oq_q, oq_d;
	logic [SW-1:0] corr_i_q, corr_i_d, corr_q_q, corr_q_d;
	logic corr_valid_q, corr_valid_d;
	logic [CW-1:0] fill;
	logic [2*SW-1:0] fifo_out;

	assign {clk_s, marker_s, sync_s, data_s} = pin_q;
	assign rise = clk_s && !clk_prev_q;
	assign fall = !clk_s && clk_prev_q;

	function automatic logic signed [15:0] scale(input logic [13:0] x,
		input logic [10:0] g);
		logic signed [25:0] p;
		p = $signed(x) * $signed({1'b0, g});
		scale = p[25:10];
	endfunction

	function automatic logic [13:0] clamp(input logic signed [17:0] v);
		if (v > dac_fe_pkg::SAT_MAX)
			clamp = dac_fe_pkg::SAT_MAX[13:0];
		else if (v < dac_fe_pkg::SAT_MIN)
			clamp = dac_fe_pkg::SAT_MIN[13:0];
		else
			clamp = v[13:0];
	endfunction

	// Word capture: divider phase and I/Q pairing
	always_comb
	begin
		slot_d = slot_q;
		i_hold_d = i_hold_q;
		i_d = i_q;
		q_d = q_q;
		pair_valid_d = 1'b0;
		if (sync_s)
			slot_d = '0;
		else
		begin
			case (clock_mode)
				dac_fe_pkg::MODE_OUT_CLOCK:
				begin
					if (rise)
					begin
						if (marker_s || slot_q == '0)
						begin
							i_hold_d = data_s;
							slot_d = 1'b1;
						end
						else
						begin
							i_d = i_hold_q;
							q_d = data_s;
							pair_valid_d = 1'b1;
							slot_d = (slot_q == 1'(dac_fe_pkg::CLK_DIV - 1))
								? '0 : slot_q + 1'b1;
						end
					end
				end
				dac_fe_pkg::MODE_DDR:
				begin
					if (rise)
						i_hold_d = data_s;
					if (fall)
					begin
						i_d = i_hold_q;
						q_d = data_s;
						pair_valid_d = 1'b1;
					end
				end
				default:
					slot_d = '0;
			endcase
		end
	end

	// Shadowed correction values go live on the low byte strobes only
	always_comb
	begin
		gi_d = gi_q;
		gq_d = gq_q;
		ph_d = ph_q;
		oi_d = oi_q;
		oq_d = oq_q;
		if (i_gain_low_byte_wr)
		begin
			gi_d = i_gain_value;
			gq_d = q_gain_value;
			ph_d = phase_value;
		end
		if (i_offset_low_byte_wr)
		begin
			oi_d = i_offset_value;
			oq_d = q_offset_value;
		end
	end

	function automatic logic signed [17:0] sum_ext(input logic signed [15:0] v);
		sum_ext = 18'(v);
	endfunction

	// One fixed correction stage, so latency never depends on clock phase
	always_comb
	begin
		logic signed [15:0] si, sq;
		logic signed [23:0] pt;
		si = scale(i_q, gi_q);
		sq = scale(q_q, gq_q);
		pt = $signed(i_q) * $signed(ph_q);
		corr_i_d = corr_i_q;
		corr_q_d = corr_q_q;
		corr_valid_d = corr_valid_q && !sample_ready;
		if (sync_s)
			corr_valid_d = 1'b0;
		else if (pair_valid_q && !corr_valid_d)
		begin
			// Gain first, then offset, leaving headroom for the offset
			corr_i_d = clamp(sum_ext(si) + 18'(signed'(oi_q)));
			corr_q_d = clamp(sum_ext(sq) + 18'(signed'(pt[23:12]))
				+ 18'(signed'(oq_q)));
			corr_valid_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			meta_q <= '0;
			pin_q <= '0;
			clk_prev_q <= 1'b0;
			slot_q <= '0;
			i_hold_q <= '0;
			i_q <= '0;
			q_q <= '0;
			pair_valid_q <= 1'b0;
			gi_q <= dac_fe_pkg::I_GAIN_RST;
			gq_q <= dac_fe_pkg::Q_GAIN_RST;
			ph_q <= dac_fe_pkg::PHASE_RST;
			oi_q <= dac_fe_pkg::I_OFFSET_RST;
			oq_q <= dac_fe_pkg::Q_OFFSET_RST;
			corr_i_q <= '0;
			corr_q_q <= '0;
			corr_valid_q <= 1'b0;
		end
		else
		begin
			meta_q <= {converter_clock_diff, i_sample_marker, sync_pulse,
				word_in};
			pin_q <= meta_q;
			clk_prev_q <= clk_s;
			slot_q <= slot_d;
			i_hold_q <= i_hold_d;
			i_q <= i_d;
			q_q <= q_d;
			pair_valid_q <= pair_valid_d;
			gi_q <= gi_d;
			gq_q <= gq_d;
			ph_q <= ph_d;
			oi_q <= oi_d;
			oq_q <= oq_d;
			corr_i_q <= corr_i_d;
			corr_q_q <= corr_q_d;
			corr_valid_q <= corr_valid_d;
		end
	end

	// Word-rate clock out, registered from the converter clock level
	assign data_clk_pin_o = clk_prev_q;
	assign data_clk_pin_oe = (clock_mode == dac_fe_pkg::MODE_OUT_CLOCK);

	// A full buffer holds the stage; pairs arriving meanwhile are lost
	sample_fifo #(.WIDTH(2 * SW), .DEPTH(DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.reset(reset),
		.flush(sync_s),
		.in_valid(corr_valid_q),
		.in_ready(sample_ready),
		.in_data({corr_i_q, corr_q_q}),
		.out_valid(conv_valid),
		.out_ready(conv_ready),
		.out_data(fifo_out),
		.count(fill)
	);
	assign {conv_i, conv_q} = fifo_out;

	// Unclocked proximity decode; samplers must synchronise it
	assign fifo_two_apart_flag = (fill <= CW'(dac_fe_pkg::TWO_APART)) ||
		(fill >= CW'(DEPTH - dac_fe_pkg::TWO_APART));
	assign fifo_one_apart_flag = (fill <= CW'(dac_fe_pkg::ONE_APART)) ||
		(fill >= CW'(DEPTH - dac_fe_pkg::ONE_APART));
	assign alarm_pin_oe = alarm_output_enable && !four_wire_serial_mode;
	assign alarm_pin_o = fifo_two_apart_flag || fifo_one_apart_flag;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_marker_tags_i: assert property (
		clock_mode == dac_fe_pkg::MODE_OUT_CLOCK && !sync_s && rise && marker_s
		|=> slot_q == 1'b1 && i_hold_q == $past(data_s) && !pair_valid_q)
		else $error("marker did not tag I word");
	a_divide_pair: assert property (
		clock_mode == dac_fe_pkg::MODE_OUT_CLOCK && !sync_s && rise &&
		!marker_s && slot_q == 1'b1
		|=> pair_valid_q && q_q == $past(data_s) && slot_q == '0)
		else $error("second word did not close pair");
	a_ddr_edges: assert property (
		clock_mode == dac_fe_pkg::MODE_DDR && !sync_s && fall
		|=> pair_valid_q && q_q == $past(data_s) && i_q == $past(i_hold_q))
		else $error("ddr pair not latched on falling edge");
	a_clock_out: assert property (
		clock_mode == dac_fe_pkg::MODE_OUT_CLOCK && rise
		|=> data_clk_pin_o && data_clk_pin_oe)
		else $error("data clock not driven");
	a_fixed_latency: assert property (
		pair_valid_q && !corr_valid_q && !sync_s |=> corr_valid_q)
		else $error("correction stage latency not one cycle");
	a_sync_clears: assert property (
		sync_s |=> !corr_valid_q && !conv_valid && slot_q == '0)
		else $error("sync did not reinitialise");
	a_alarm_gate: assert property (
		alarm_pin_oe |-> alarm_output_enable && !four_wire_serial_mode)
		else $error("alarm pin driven while gated");
	a_offset_load: assert property (
		!i_offset_low_byte_wr |=> $stable(oi_q) && $stable(oq_q))
		else $error("offset changed without low byte write");
	a_gain_load: assert property (
		i_gain_low_byte_wr |=> gi_q == $past(i_gain_value) &&
		ph_q == $past(phase_value))
		else $error("gain or phase not loaded");
	a_alarm_nest: assert property (
		fifo_one_apart_flag |-> fifo_two_apart_flag)
		else $error("one-apart alarm without two-apart");

	c_out_clock_pair: cover property (
		clock_mode == dac_fe_pkg::MODE_OUT_CLOCK && pair_valid_q);
	c_ddr_pair: cover property (clock_mode == dac_fe_pkg::MODE_DDR &&
		pair_valid_q);
	c_fifo_full: cover property (!sample_ready);
	c_sync_seen: cover property (sync_s && corr_valid_q);
endmodule

// *** test/iq_source.sv ***
`timescale 1ns/1ps

module iq_source (
	input wire logic clk_sys,
	input wire dac_fe_pkg::clock_mode_e mode,
	output logic clk_pin,
	output logic marker,
	output logic [13:0] word
);
	initial
	begin
		clk_pin = 1'b0;
		marker = 1'b0;
		word = 14'h0000;
	end
	// Each level holds three cycles, above the two-cycle floor
	task automatic lvl(input logic c, input logic m, input logic [13:0] w);
		@(negedge clk_sys);
		clk_pin = c;
		marker = m;
		word = w;
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic send(input logic [13:0] i, input logic [13:0] q);
		lvl(1'b1, 1'b1, i);
		if (mode == dac_fe_pkg::MODE_DDR)
			lvl(1'b0, 1'b0, q);
		else
		begin
			lvl(1'b0, 1'b1, i);
			lvl(1'b1, 1'b0, q);
			lvl(1'b0, 1'b0, q);
		end
		// Released bus shows the inverse, never a stale word
		lvl(1'b0, 1'b0, ~q);
	endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end

module testbench;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	dac_fe_pkg::clock_mode_e mode = dac_fe_pkg::MODE_OUT_CLOCK;
	logic sync = 0, gwr = 0, owr = 0, aen = 1, fw = 0, crdy = 0;
	logic [10:0] gv = 0, qv = 0;
	logic [9:0] pv = 0;
	logic [12:0] ov = 0, qo = 0;
	logic cclk, mark, dclk, dclk_oe, two, one, apin, apin_oe, srdy, cval;
	logic [13:0] word;
	logic [13:0] ci, cq;
	int n_fail = 0, comparisons = 0, dclk_n = 0;
	// Active values after reset
	int gi = 1280, gq = 536, ph = -512, oi = -2560, oq = -646;

	always #2.5 clk_sys = ~clk_sys;
	always @(posedge dclk) dclk_n++;

	iq_source iq_source_i (.clk_sys(clk_sys), .mode(mode), .clk_pin(cclk),
		.marker(mark), .word(word));
	dac_input_qmc dac_input_qmc_i (.clk_sys(clk_sys), .reset(reset),
		.clock_mode(mode), .converter_clock_diff(cclk),
		.i_sample_marker(mark), .sync_pulse(sync), .word_in(word),
		.data_clk_pin_o(dclk), .data_clk_pin_oe(dclk_oe),
		.i_gain_value(gv), .q_gain_value(qv), .phase_value(pv),
		.i_offset_value(ov), .q_offset_value(qo),
		.i_gain_low_byte_wr(gwr), .i_offset_low_byte_wr(owr),
		.alarm_output_enable(aen), .four_wire_serial_mode(fw),
		.fifo_two_apart_flag(two), .fifo_one_apart_flag(one),
		.alarm_pin_o(apin), .alarm_pin_oe(apin_oe), .sample_ready(srdy),
		.conv_valid(cval), .conv_ready(crdy), .conv_i(ci), .conv_q(cq));

	function automatic logic [13:0] sat(int v);
		return v > 8191 ? 14'h1fff : v < -8192 ? 14'h2000 : 14'(v);
	endfunction
	function automatic logic [13:0] ei(int i);
		return sat(((i * gi) >>> 10) + oi);
	endfunction
	function automatic logic [13:0] eq(int i, int q);
		return sat(((q * gq) >>> 10) + ((i * ph) >>> 12) + oq);
	endfunction

	task automatic cfg(int g1, g2, p, o1, o2, bit sg, bit so);
		@(negedge clk_sys);
		{gv, qv, pv, ov, qo} = {11'(g1), 11'(g2), 10'(p), 13'(o1), 13'(o2)};
		gwr = sg;
		owr = so;
		@(negedge clk_sys);
		{gwr, owr} = 2'b00;
		if (sg)
			{gi, gq, ph} = {g1, g2, p};
		if (so)
			{oi, oq} = {o1, o2};
	endtask
	task automatic pop(logic [13:0] a, logic [13:0] b);
		int n;
		n = 0;
		while (cval !== 1'b1 && n < 40)
		begin
			@(negedge clk_sys);
			n++;
		end
		`CHK(cval, 1'b1)
		`CHK(ci, a)
		`CHK(cq, b)
		crdy = 1'b1;
		@(negedge clk_sys);
		crdy = 1'b0;
	endtask
	task automatic pair(int i, int q);
		logic [13:0] a, b;
		a = ei(i);
		b = eq(i, q);
		iq_source_i.send(14'(i), 14'(q));
		pop(a, b);
	endtask

	task automatic t_reset;
		`CHK({cval, srdy, dclk, dclk_oe}, 4'b0101)
		`CHK({two, one, apin}, 3'b111)
		for (int k = 0; k < 4; k++)
		begin
			@(negedge clk_sys);
			{fw, aen} = 2'(k);
			#1 `CHK(apin_oe, aen & ~fw)
		end
		{fw, aen} = 2'b01;
		$display("test reset done");
	endtask
	task automatic t_shadow;
		cfg(1024, 1024, 0, 100, -100, 0, 0);
		pair(1000, -2000);
		cfg(1024, 1024, 0, 100, -100, 1, 0);
		pair(1000, -2000);
		cfg(700, 1500, 300, 100, -100, 0, 1);
		pair(-3000, 2500);
		$display("test shadow done");
	endtask
	task automatic t_clamp;
		cfg(2047, 2047, 0, 4095, -4096, 1, 1);
		pair(8191, -8192);
		cfg(512, 512, 0, 4095, -4096, 1, 1);
		pair(8000, -8000);
		$display("test clamp done");
	endtask
	task automatic t_ddr;
		@(negedge clk_sys);
		mode = dac_fe_pkg::MODE_DDR;
		#1 `CHK(dclk_oe, 1'b0)
		pair(300, -700);
		pair(-1234, 4321);
		mode = dac_fe_pkg::MODE_OUT_CLOCK;
		$display("test ddr done");
	endtask
	task automatic t_fifo;
		logic [13:0] a[4], b[4];
		dclk_n = 0;
		for (int k = 0; k < 4; k++)
		begin
			a[k] = ei(k * 100 + 1);
			b[k] = eq(k * 100 + 1, -k * 50);
			iq_source_i.send(14'(k * 100 + 1), 14'(-k * 50));
		end
		repeat (8) @(negedge clk_sys);
		`CHK(dclk_n > 0, 1'b1)
		`CHK({srdy, two, one}, 3'b011)
		pop(a[0], b[0]);
		pop(a[1], b[1]);
		`CHK({srdy, two, one}, 3'b110)
		pop(a[2], b[2]);
		pop(a[3], b[3]);
		`CHK({cval, one, apin}, 3'b011)
		$display("test fifo done");
	endtask
	task automatic t_sync;
		iq_source_i.send(14'h0100, 14'h0200);
		iq_source_i.send(14'h0300, 14'h0400);
		repeat (8) @(negedge clk_sys);
		`CHK(cval, 1'b1)
		sync = 1'b1;
		repeat (3) @(negedge clk_sys);
		sync = 1'b0;
		repeat (4) @(negedge clk_sys);
		`CHK({cval, srdy}, 2'b01)
		pair(-50, 60);
		$display("test sync done");
	endtask

	task automatic conclude;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run is a few hundred cycles; the 20000-cycle limit is ample margin
	initial
	begin
		#100000;
		n_fail++;
		conclude();
	end
	initial
	begin
		repeat (5) @(negedge clk_sys);
		reset = 1'b0;
		t_reset();
		t_shadow();
		t_clamp();
		t_ddr();
		t_fifo();
		t_sync();
		conclude();
	end
endmodule
